// File: src/fabric_port_defines.svh
// Timing, reset values and field codes of the direct fabric memory port
`ifndef FABRIC_PORT_DEFINES_SVH
`define FABRIC_PORT_DEFINES_SVH

`define FP_RESET_STAGES 2
`define FP_STORE_DEPTH 32
`define FP_RESP_OKAY 2'h0
`define FP_RESP_SLVERR 2'h2
`define FP_BURST_FIXED 2'h0
`define FP_BURST_INCR 2'h1
`define FP_BEAT_SIZE 3'h6
`define FP_LOCK_NORMAL 2'h0
`define FP_CACHE_NONE 4'h0
`define FP_PROT_NONE 3'h0
`define FP_BEAT_LSB 6
`define FP_ALERT_NONE 19'h00000

`endif

// File: src/fabric_port_pkg.sv
// Types shared by both ends of the direct fabric memory port
package fabric_port_pkg;
  typedef logic [6:0] axi_id_t;
  typedef logic [32:0] axi_addr_t;
  typedef logic [3:0] axi_len_t;
  typedef logic [2:0] axi_qos_t;
  typedef logic [1:0] axi_resp_t;
  typedef logic [511:0] beat_data_t;
  typedef logic [31:0] lane_strb_t;
  typedef logic [255:0] local_word_t;
  typedef logic [7:0] check_byte_t;
  typedef logic [18:0] alert_vec_t;
  typedef logic [4:0] word_idx_t;
  typedef enum logic [1:0] {W_IDLE, W_DATA, W_HI, W_RESP} wr_state_t;
  typedef enum logic [1:0] {R_IDLE, R_LO, R_HI, R_OUT} rd_state_t;
  typedef enum logic [2:0] {H_IDLE, H_AW, H_W, H_B, H_AR, H_R} host_state_t;

  // Byte-wise XOR fold kept beside every stored word
  function automatic check_byte_t fold_check(input local_word_t w);
    check_byte_t c;
    c = 8'h00;
    for (int i = 0; i < 32; i++)
    begin
      c = c ^ w[i*8 +: 8];
    end
    return c;
  endfunction : fold_check
endpackage : fabric_port_pkg

// File: src/direct_fabric_port_if.sv
// Per-channel port between the memory subsystem and fabric initiator logic
`timescale 1ns/1ps
interface direct_fabric_port_if;
  import fabric_port_pkg::*;
  logic fabric_port_clock;
  logic fabric_port_reset_low;
  logic check_mismatch_flag;
  alert_vec_t controller_alert_vector;
  logic controller_alert_any;
  axi_id_t awid;
  axi_addr_t awaddr;
  axi_len_t awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic [1:0] awlock;
  logic [3:0] awcache;
  logic [2:0] awprot;
  axi_qos_t awqos;
  logic awvalid;
  logic awready;
  axi_id_t wid;
  beat_data_t wdata;
  lane_strb_t wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  axi_id_t bid;
  axi_resp_t bresp;
  logic bvalid;
  logic bready;
  axi_id_t arid;
  axi_addr_t araddr;
  axi_len_t arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic [1:0] arlock;
  logic [3:0] arcache;
  logic [2:0] arprot;
  axi_qos_t arqos;
  logic arvalid;
  logic arready;
  axi_id_t rid;
  beat_data_t rdata;
  axi_resp_t rresp;
  logic rlast;
  logic rvalid;
  logic rready;

  modport dev (
    output fabric_port_clock, fabric_port_reset_low, check_mismatch_flag,
    output controller_alert_vector, controller_alert_any,
    input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awqos, awvalid,
    output awready,
    input wid, wdata, wstrb, wlast, wvalid,
    output wready, bid, bresp, bvalid,
    input bready,
    input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos, arvalid,
    output arready, rid, rdata, rresp, rlast, rvalid,
    input rready
  );

  modport host (
    input fabric_port_clock, fabric_port_reset_low, check_mismatch_flag,
    input controller_alert_vector, controller_alert_any,
    output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awqos, awvalid,
    input awready,
    output wid, wdata, wstrb, wlast, wvalid,
    input wready, bid, bresp, bvalid,
    output bready,
    output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos, arvalid,
    input arready, rid, rdata, rresp, rlast, rvalid,
    output rready
  );
endinterface : direct_fabric_port_if

// File: src/local_word_store.sv
// Local-bus word store: byte-masked 256-bit writes, check byte per word
`timescale 1ns/1ps
`include "fabric_port_defines.svh"
module local_word_store (
  input wire logic clk, // Controller clock
  input wire logic ce, // Clock enable
  input wire logic wr_en, // Write one word
  input wire fabric_port_pkg::word_idx_t wr_idx, // Write word index
  input wire fabric_port_pkg::local_word_t wr_data, // Write word
  input wire fabric_port_pkg::lane_strb_t wr_mask, // Byte enables
  input wire fabric_port_pkg::word_idx_t rd_idx, // Read word index
  output fabric_port_pkg::local_word_t rd_data, // Read word
  output logic rd_bad // Check byte disagrees
);
  import fabric_port_pkg::*;

  local_word_t words [`FP_STORE_DEPTH];
  check_byte_t checks [`FP_STORE_DEPTH];
  local_word_t merged;

  always_comb
  begin
    merged = words[wr_idx];
    for (int i = 0; i < 32; i++)
    begin
      if (wr_mask[i])
      begin
        merged[i*8 +: 8] = wr_data[i*8 +: 8];
      end
    end
  end

  // Memory contents carry no reset; read before write returns unknown data
  always_ff @(posedge clk)
  begin
    if (ce && wr_en)
    begin
      words[wr_idx] <= merged;
      checks[wr_idx] <= fold_check(merged);
    end
  end

  assign rd_data = words[rd_idx];
  assign rd_bad = (fold_check(words[rd_idx]) != checks[rd_idx]);
endmodule : local_word_store

// File: src/fabric_port_responder.sv
// Device end: AXI responder, fabric clock/reset and alert outputs per channel
// Summary of operation
// - Drive fabric clock from controller clock.
// - Drive active-low fabric reset from controller reset.
// - Pulse mismatch flag on read/write check failure.
// - Present 19-bit controller alert vector.
// - Alert summary is OR of vector.
// - Initiator drives write-address fields at documented widths.
// - Burst length sets beats; exactly that many.
// - Initiator supplies write ID, data, strobes.
// - Write-last only on final write beat.
// - One write response per write, held until ready.
// - Initiator drives read-address fields at documented widths.
// - Read ID echoes the read-address ID.
// - Read data with status; last on final beat.
// - Valid/ready handshake on every channel.
// - Initiator supplies QoS with every address.
// - Fabric logic uses provided clock and reset.
// - Convert 512-bit beats into 256-bit local words.
`timescale 1ns/1ps
`include "fabric_port_defines.svh"
module fabric_port_responder (
  direct_fabric_port_if.dev io, // Fabric-side channel port
  input wire logic clk, // Controller global clock
  input wire logic rst_n, // Controller global reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire fabric_port_pkg::alert_vec_t alert_set, // Controller error events
  input wire fabric_port_pkg::alert_vec_t alert_clear, // Alert acknowledge per bit
  input wire logic wr_check_fail // Write-path check failure pulse
);
  import fabric_port_pkg::*;

  typedef struct packed {
    logic [`FP_RESET_STAGES-1:0] rst_pipe;
    wr_state_t ws;
    axi_id_t wid;
    logic [3:0] wbeat;
    logic wfixed;
    axi_len_t wlen;
    axi_len_t wcnt;
    local_word_t whi;
    lane_strb_t wstrb;
    rd_state_t rs;
    axi_id_t rid;
    logic [3:0] rbeat;
    logic rfixed;
    axi_len_t rlen;
    axi_len_t rcnt;
    beat_data_t rdata;
    logic rbad;
    logic crc;
    alert_vec_t alerts;
    logic any;
  } dev_state_t;

  dev_state_t st_ff;
  dev_state_t nxt_st;
  logic port_up;
  logic st_wr_en;
  word_idx_t st_wr_idx;
  local_word_t st_wr_data;
  lane_strb_t st_wr_mask;
  word_idx_t st_rd_idx;
  local_word_t st_rd_data;
  logic st_rd_bad;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  local_word_store store (
    .clk(clk),
    .ce(ce),
    .wr_en(st_wr_en),
    .wr_idx(st_wr_idx),
    .wr_data(st_wr_data),
    .wr_mask(st_wr_mask),
    .rd_idx(st_rd_idx),
    .rd_data(st_rd_data),
    .rd_bad(st_rd_bad)
  );

  assign io.fabric_port_clock = clk;
  assign io.fabric_port_reset_low = st_ff.rst_pipe[`FP_RESET_STAGES-1];
  assign port_up = st_ff.rst_pipe[`FP_RESET_STAGES-1];

  // Readies only while the fabric is out of reset
  assign io.awready = port_up && (st_ff.ws == W_IDLE);
  assign io.wready = port_up && (st_ff.ws == W_DATA);
  assign io.arready = port_up && (st_ff.rs == R_IDLE);
  assign io.bvalid = port_up && (st_ff.ws == W_RESP);
  assign io.rvalid = port_up && (st_ff.rs == R_OUT);
  assign io.bid = st_ff.wid;
  assign io.bresp = `FP_RESP_OKAY;
  assign io.rid = st_ff.rid;
  assign io.rdata = st_ff.rdata;
  assign io.rresp = st_ff.rbad ? `FP_RESP_SLVERR : `FP_RESP_OKAY;
  assign io.rlast = (st_ff.rcnt == st_ff.rlen);
  assign io.check_mismatch_flag = st_ff.crc;
  assign io.controller_alert_vector = st_ff.alerts;
  assign io.controller_alert_any = st_ff.any;

  assign aw_hs = io.awvalid && io.awready;
  assign w_hs = io.wvalid && io.wready;
  assign ar_hs = io.arvalid && io.arready;

  // Store port steering: low half on the beat handshake, high half next cycle
  always_comb
  begin
    st_wr_en = 1'b0;
    st_wr_idx = {st_ff.wbeat, 1'b0};
    st_wr_data = io.wdata[255:0];
    st_wr_mask = io.wstrb;
    if (st_ff.ws == W_DATA)
    begin
      st_wr_en = w_hs;
    end
    else if (st_ff.ws == W_HI)
    begin
      st_wr_en = 1'b1;
      st_wr_idx = {st_ff.wbeat, 1'b1};
      st_wr_data = st_ff.whi;
      st_wr_mask = st_ff.wstrb;
    end
    st_rd_idx = {st_ff.rbeat, (st_ff.rs == R_HI)};
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rst_pipe = {st_ff.rst_pipe[`FP_RESET_STAGES-2:0], 1'b1};

    unique case (st_ff.ws)
      W_IDLE:
      begin
        if (aw_hs)
        begin
          nxt_st.wid = io.awid;
          nxt_st.wbeat = io.awaddr[`FP_BEAT_LSB +: 4];
          nxt_st.wfixed = (io.awburst == `FP_BURST_FIXED);
          nxt_st.wlen = io.awlen;
          nxt_st.wcnt = 4'h0;
          nxt_st.ws = W_DATA;
        end
      end
      W_DATA:
      begin
        if (w_hs)
        begin
          nxt_st.whi = io.wdata[511:256];
          nxt_st.wstrb = io.wstrb;
          nxt_st.ws = W_HI;
        end
      end
      W_HI:
      begin
        // Burst ends on the counted beat; a wrong write-last is not trusted
        if (st_ff.wcnt == st_ff.wlen)
        begin
          nxt_st.ws = W_RESP;
        end
        else
        begin
          nxt_st.wcnt = st_ff.wcnt + 4'h1;
          nxt_st.wbeat = st_ff.wfixed ? st_ff.wbeat : st_ff.wbeat + 4'h1;
          nxt_st.ws = W_DATA;
        end
      end
      W_RESP:
      begin
        if (io.bready)
        begin
          nxt_st.ws = W_IDLE;
        end
      end
    endcase

    unique case (st_ff.rs)
      R_IDLE:
      begin
        if (ar_hs)
        begin
          nxt_st.rid = io.arid;
          nxt_st.rbeat = io.araddr[`FP_BEAT_LSB +: 4];
          nxt_st.rfixed = (io.arburst == `FP_BURST_FIXED);
          nxt_st.rlen = io.arlen;
          nxt_st.rcnt = 4'h0;
          nxt_st.rs = R_LO;
        end
      end
      R_LO:
      begin
        nxt_st.rdata[255:0] = st_rd_data;
        nxt_st.rbad = st_rd_bad;
        nxt_st.rs = R_HI;
      end
      R_HI:
      begin
        nxt_st.rdata[511:256] = st_rd_data;
        nxt_st.rbad = st_ff.rbad | st_rd_bad;
        nxt_st.rs = R_OUT;
      end
      R_OUT:
      begin
        if (io.rready)
        begin
          if (st_ff.rcnt == st_ff.rlen)
          begin
            nxt_st.rs = R_IDLE;
          end
          else
          begin
            nxt_st.rcnt = st_ff.rcnt + 4'h1;
            nxt_st.rbeat = st_ff.rfixed ? st_ff.rbeat : st_ff.rbeat + 4'h1;
            nxt_st.rs = R_LO;
          end
        end
      end
    endcase

    // One pulse per failed check, either direction
    nxt_st.crc = wr_check_fail || (((st_ff.rs == R_LO) || (st_ff.rs == R_HI)) && st_rd_bad);
    // New events win over an acknowledge in the same cycle
    nxt_st.alerts = (st_ff.alerts & ~alert_clear) | alert_set;
    nxt_st.any = |nxt_st.alerts;

    // Fabric held in reset: drop any half-done transfer
    if (!port_up)
    begin
      nxt_st.ws = W_IDLE;
      nxt_st.rs = R_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.ws <= W_IDLE;
      st_ff.rs <= R_IDLE;
      st_ff.alerts <= `FP_ALERT_NONE;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : fabric_port_responder

// File: src/fabric_port_initiator.sv
// Fabric end: AXI initiator turning user commands into bursts on the port
`timescale 1ns/1ps
`include "fabric_port_defines.svh"
module fabric_port_initiator (
  direct_fabric_port_if.host io, // Port toward the memory subsystem
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Command taken
  input wire logic cmd_write, // 1 write burst, 0 read burst
  input wire fabric_port_pkg::axi_id_t cmd_id, // Transaction ID
  input wire fabric_port_pkg::axi_addr_t cmd_addr, // First-beat byte address
  input wire fabric_port_pkg::axi_len_t cmd_len, // Beats minus one
  input wire fabric_port_pkg::axi_qos_t cmd_qos, // Quality of service
  input wire logic wr_valid, // Write beat offered
  output logic wr_ready, // Write beat taken
  input wire fabric_port_pkg::beat_data_t wr_data, // Write beat data
  input wire fabric_port_pkg::lane_strb_t wr_strb, // Write byte strobes
  output logic wr_done, // Write response pulse
  output fabric_port_pkg::axi_resp_t wr_resp, // Write response status
  output logic rd_valid, // Read beat pulse
  output fabric_port_pkg::beat_data_t rd_data, // Read beat data
  output fabric_port_pkg::axi_id_t rd_id, // Read beat ID
  output fabric_port_pkg::axi_resp_t rd_resp, // Read beat status
  output logic rd_last // Last beat of read burst
);
  import fabric_port_pkg::*;

  typedef struct packed {
    host_state_t hs;
    axi_id_t id;
    axi_addr_t addr;
    axi_len_t len;
    axi_len_t cnt;
    axi_qos_t qos;
    beat_data_t wdata;
    lane_strb_t wstrb;
    logic wvalid;
    logic wlast;
    logic wr_done;
    axi_resp_t wr_resp;
    logic rd_valid;
    beat_data_t rd_data;
    axi_id_t rd_id;
    axi_resp_t rd_resp;
    logic rd_last;
  } host_reg_t;

  host_reg_t st_ff;
  host_reg_t nxt_st;
  logic clk;
  logic rst_n;
  logic load;

  assign clk = io.fabric_port_clock;
  assign rst_n = io.fabric_port_reset_low;

  assign io.awid = st_ff.id;
  assign io.awaddr = st_ff.addr;
  assign io.awlen = st_ff.len;
  assign io.awsize = `FP_BEAT_SIZE;
  assign io.awburst = `FP_BURST_INCR;
  assign io.awlock = `FP_LOCK_NORMAL;
  assign io.awcache = `FP_CACHE_NONE;
  assign io.awprot = `FP_PROT_NONE;
  assign io.awqos = st_ff.qos;
  assign io.awvalid = (st_ff.hs == H_AW);
  assign io.wid = st_ff.id;
  assign io.wdata = st_ff.wdata;
  assign io.wstrb = st_ff.wstrb;
  assign io.wlast = st_ff.wlast;
  assign io.wvalid = st_ff.wvalid;
  assign io.bready = (st_ff.hs == H_B);
  assign io.arid = st_ff.id;
  assign io.araddr = st_ff.addr;
  assign io.arlen = st_ff.len;
  assign io.arsize = `FP_BEAT_SIZE;
  assign io.arburst = `FP_BURST_INCR;
  assign io.arlock = `FP_LOCK_NORMAL;
  assign io.arcache = `FP_CACHE_NONE;
  assign io.arprot = `FP_PROT_NONE;
  assign io.arqos = st_ff.qos;
  assign io.arvalid = (st_ff.hs == H_AR);
  assign io.rready = (st_ff.hs == H_R);

  assign cmd_ready = (st_ff.hs == H_IDLE);
  // No new beat once the last one is queued
  assign wr_ready = (st_ff.hs == H_W) && (!st_ff.wvalid || io.wready) && !(st_ff.wvalid && st_ff.wlast);
  assign load = wr_valid && wr_ready;
  assign wr_done = st_ff.wr_done;
  assign wr_resp = st_ff.wr_resp;
  assign rd_valid = st_ff.rd_valid;
  assign rd_data = st_ff.rd_data;
  assign rd_id = st_ff.rd_id;
  assign rd_resp = st_ff.rd_resp;
  assign rd_last = st_ff.rd_last;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wr_done = 1'b0;
    nxt_st.rd_valid = 1'b0;
    unique case (st_ff.hs)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          nxt_st.id = cmd_id;
          nxt_st.addr = cmd_addr;
          nxt_st.len = cmd_len;
          nxt_st.qos = cmd_qos;
          nxt_st.cnt = 4'h0;
          nxt_st.hs = cmd_write ? H_AW : H_AR;
        end
      end
      H_AW:
      begin
        if (io.awready)
        begin
          nxt_st.hs = H_W;
        end
      end
      H_W:
      begin
        if (st_ff.wvalid && io.wready)
        begin
          nxt_st.wvalid = 1'b0;
          if (st_ff.wlast)
          begin
            nxt_st.hs = H_B;
          end
        end
        if (load)
        begin
          nxt_st.wvalid = 1'b1;
          nxt_st.wdata = wr_data;
          nxt_st.wstrb = wr_strb;
          nxt_st.wlast = (st_ff.cnt == st_ff.len);
          nxt_st.cnt = st_ff.cnt + 4'h1;
        end
      end
      H_B:
      begin
        if (io.bvalid)
        begin
          nxt_st.wr_done = 1'b1;
          nxt_st.wr_resp = io.bresp;
          nxt_st.hs = H_IDLE;
        end
      end
      H_AR:
      begin
        if (io.arready)
        begin
          nxt_st.hs = H_R;
        end
      end
      H_R:
      begin
        if (io.rvalid)
        begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data = io.rdata;
          nxt_st.rd_id = io.rid;
          nxt_st.rd_resp = io.rresp;
          nxt_st.rd_last = io.rlast;
          if (io.rlast)
          begin
            nxt_st.hs = H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.hs <= H_IDLE;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : fabric_port_initiator

// File: verification/fabric_port_assertions.sv
// Protocol checker watching the port between initiator and responder
`timescale 1ns/1ps
module fabric_port_assertions (
  input logic fabric_port_clock, // Port clock
  input logic fabric_port_reset_low, // Port reset
  input fabric_port_pkg::alert_vec_t controller_alert_vector, // Alerts
  input logic controller_alert_any, // Alert summary
  input fabric_port_pkg::axi_id_t awid, // AW id
  input fabric_port_pkg::axi_len_t awlen, // AW length
  input logic awvalid, // AW valid
  input logic awready, // AW ready
  input logic wvalid, // W valid
  input logic wready, // W ready
  input logic wlast, // W last
  input fabric_port_pkg::axi_id_t bid, // B id
  input fabric_port_pkg::axi_resp_t bresp, // B status
  input logic bvalid, // B valid
  input logic bready, // B ready
  input fabric_port_pkg::axi_id_t arid, // AR id
  input fabric_port_pkg::axi_len_t arlen, // AR length
  input logic arvalid, // AR valid
  input logic arready, // AR ready
  input fabric_port_pkg::axi_id_t rid, // R id
  input fabric_port_pkg::beat_data_t rdata, // R data
  input logic rlast, // R last
  input logic rvalid, // R valid
  input logic rready // R ready
);
  import fabric_port_pkg::*;
  axi_len_t aw_len_ff, ar_len_ff, wcnt_ff, rcnt_ff;
  axi_id_t aw_id_ff, ar_id_ff;

  // Loaded on each address handshake, so no reset is needed
  always_ff @(posedge fabric_port_clock)
  begin
    if (awvalid && awready)
    begin
      aw_len_ff <= awlen;
      aw_id_ff <= awid;
      wcnt_ff <= '0;
    end
    else if (wvalid && wready)
      wcnt_ff <= wcnt_ff + 4'h1;
    if (arvalid && arready)
    begin
      ar_len_ff <= arlen;
      ar_id_ff <= arid;
      rcnt_ff <= '0;
    end
    else if (rvalid && rready)
      rcnt_ff <= rcnt_ff + 4'h1;
  end

  default clocking cb @(posedge fabric_port_clock);
  endclocking
  default disable iff (!fabric_port_reset_low);

  sequence aw_take_s;
    awvalid && awready;
  endsequence
  sequence w_take_s;
    wvalid && wready;
  endsequence
  sequence ar_take_s;
    arvalid && arready;
  endsequence
  sequence r_take_s;
    rvalid && rready;
  endsequence

  reset_quiet_a: assert property ($rose(fabric_port_reset_low) |->
    !$past(awready) && !$past(wready) && !$past(bvalid) && !$past(arready) && !$past(rvalid))
    else $error("handshake output active during reset");
  alert_or_a: assert property (controller_alert_any == (|controller_alert_vector))
    else $error("alert summary differs from vector OR");
  aw_opens_a: assert property (aw_take_s |=> wready && !awready)
    else $error("write data channel not opened after address");
  wlast_place_a: assert property (w_take_s |-> wlast == (wcnt_ff == aw_len_ff))
    else $error("write last on wrong beat");
  bresp_after_a: assert property (w_take_s ##0 (wcnt_ff == aw_len_ff) |->
    ##2 bvalid && bid == aw_id_ff && bresp == 2'h0)
    else $error("write response missing or wrong after last beat");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bid) && $stable(bresp))
    else $error("write response dropped before ready");
  rid_echo_a: assert property (rvalid |-> rid == ar_id_ff)
    else $error("read id differs from address id");
  rlast_count_a: assert property (r_take_s |-> rlast == (rcnt_ff == ar_len_ff))
    else $error("read last on wrong beat");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rlast))
    else $error("read beat changed before ready");
  ar_busy_a: assert property (ar_take_s |=> !arready [*2] ##1 (rvalid && !arready))
    else $error("read address timing wrong");
endmodule : fabric_port_assertions

// File: verification/fabric_axi_memory_port_bench.sv
// Self-checking bench: initiator and responder joined over one port
`timescale 1ns/1ps
module fabric_axi_memory_port_bench;
  import fabric_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  alert_vec_t alert_set = '0;
  alert_vec_t alert_clear = '0;
  logic wr_check_fail = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  axi_id_t cmd_id = '0;
  axi_addr_t cmd_addr = '0;
  axi_len_t cmd_len = '0;
  axi_qos_t cmd_qos = '0;
  logic wr_valid = 1'b0;
  beat_data_t wr_data = '0;
  lane_strb_t wr_strb = '0;
  logic cmd_ready, wr_ready, wr_done, rd_valid, rd_last;
  axi_resp_t wr_resp, rd_resp;
  beat_data_t rd_data;
  axi_id_t rd_id;
  beat_data_t mem [16];
  int miscompares = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  direct_fabric_port_if port_if ();
  fabric_port_responder fabric_port_responder_inst (.io(port_if), .clk(clk), .rst_n(rst_n), .ce(ce),
    .alert_set(alert_set), .alert_clear(alert_clear), .wr_check_fail(wr_check_fail));
  fabric_port_initiator fabric_port_initiator_inst (.io(port_if), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_qos(cmd_qos), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_done(wr_done), .wr_resp(wr_resp), .rd_valid(rd_valid), .rd_data(rd_data), .rd_id(rd_id),
    .rd_resp(rd_resp), .rd_last(rd_last));
  fabric_port_assertions fabric_port_assertions_inst (.fabric_port_clock(port_if.fabric_port_clock),
    .fabric_port_reset_low(port_if.fabric_port_reset_low), .controller_alert_vector(port_if.controller_alert_vector),
    .controller_alert_any(port_if.controller_alert_any), .awid(port_if.awid), .awlen(port_if.awlen),
    .awvalid(port_if.awvalid), .awready(port_if.awready), .wvalid(port_if.wvalid), .wready(port_if.wready),
    .wlast(port_if.wlast), .bid(port_if.bid), .bresp(port_if.bresp), .bvalid(port_if.bvalid),
    .bready(port_if.bready), .arid(port_if.arid), .arlen(port_if.arlen), .arvalid(port_if.arvalid),
    .arready(port_if.arready), .rid(port_if.rid), .rdata(port_if.rdata), .rlast(port_if.rlast),
    .rvalid(port_if.rvalid), .rready(port_if.rready));

  task automatic check(input logic [511:0] seen, input logic [511:0] expected);
    check_count++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expected);
    end
  endtask : check

  task automatic issue(input logic wr, input axi_id_t id, input logic [3:0] beat, input axi_len_t len);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_id = id;
    cmd_addr = {23'h0, beat, 6'h0};
    cmd_len = len;
    cmd_qos = len[2:0];
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic write_burst(input axi_id_t id, input logic [3:0] beat, input axi_len_t len, input lane_strb_t s);
    beat_data_t d;
    logic [3:0] b;
    issue(1'b1, id, beat, len);
    for (int k = 0; k <= len; k++)
    begin
      b = beat + k[3:0];
      d = {16{id, 1'h0, b, len, 16'hC3A5}};
      wr_valid = 1'b1;
      wr_data = d;
      wr_strb = s;
      for (int n = 0; n < 40; n++)
      begin
        @(posedge clk);
        if (wr_ready === 1'b1) break;
      end
      // One strobe bit covers the same byte in both halves
      for (int i = 0; i < 64; i++)
        if (s[i % 32]) mem[b][i*8 +: 8] = d[i*8 +: 8];
      @(negedge clk);
    end
    wr_valid = 1'b0;
    // Pulse stands a full cycle, so look at it mid-cycle
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (wr_done === 1'b1) break;
    end
    check(wr_done, 1'h1);
    check(wr_resp, 2'h0);
  endtask : write_burst

  task automatic read_burst(input axi_id_t id, input logic [3:0] beat, input axi_len_t len);
    logic [3:0] b;
    int k;
    k = 0;
    b = beat;
    issue(1'b0, id, beat, len);
    for (int n = 0; n < 300 && k <= len; n++)
    begin
      @(negedge clk);
      if (rd_valid === 1'b1)
      begin
        check(rd_data, mem[b]);
        check(rd_id, id);
        check(rd_resp, 2'h0);
        check(rd_last, k == len);
        k++;
        b = b + 4'h1;
      end
    end
    check(k, len + 1);
  endtask : read_burst

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #(25 * 3000);
    miscompares++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(port_if.fabric_port_reset_low, 1'h0);
    @(negedge clk);
    check(port_if.fabric_port_reset_low, 1'h1);
    check(port_if.controller_alert_vector, 19'h0);
    check(port_if.check_mismatch_flag, 1'h0);
    // Clock copy settles after the bench clock in the same step
    #1;
    check(port_if.fabric_port_clock, 1'h0);
    @(posedge clk);
    #1;
    check(port_if.fabric_port_clock, 1'h1);
    $display("test reset done, mismatches %0d", miscompares);
    // Start at beat 14 so the 16-beat burst wraps
    write_burst(7'h11, 4'hE, 4'hF, 32'hFFFFFFFF);
    read_burst(7'h22, 4'hE, 4'hF);
    write_burst(7'h7F, 4'h0, 4'h0, 32'h000000F0);
    read_burst(7'h00, 4'hF, 4'h1);
    $display("test bursts done, mismatches %0d", miscompares);
    @(negedge clk);
    alert_set = 19'h40001;
    @(negedge clk);
    check(port_if.controller_alert_vector, 19'h40001);
    check(port_if.controller_alert_any, 1'h1);
    alert_set = 19'h00001;
    alert_clear = 19'h7FFFF;
    @(negedge clk);
    check(port_if.controller_alert_vector, 19'h00001);
    alert_set = 19'h0;
    wr_check_fail = 1'b1;
    @(negedge clk);
    alert_clear = 19'h0;
    wr_check_fail = 1'b0;
    check(port_if.controller_alert_any, 1'h0);
    check(port_if.check_mismatch_flag, 1'h1);
    @(negedge clk);
    check(port_if.check_mismatch_flag, 1'h0);
    $display("test alerts done, mismatches %0d", miscompares);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    check(port_if.fabric_port_reset_low, 1'h0);
    check({port_if.awready, port_if.arready, port_if.wready, port_if.bvalid, port_if.rvalid}, 5'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check(port_if.fabric_port_reset_low, 1'h1);
    read_burst(7'h33, 4'h5, 4'h0);
    $display("test second reset done, mismatches %0d", miscompares);
    results();
  end
endmodule : fabric_axi_memory_port_bench
